/* File: itr_port.v */
// Summary of operation
// R1: first write byte sets register pointer
// R2: controller always sends pointer in writes
// R3: acknowledge matching address before pointer byte
// R4: next two bytes stored MSB first, acked
// R5: start or stop both end writes
// R6: read returns register at stored pointer
// R7: pointer-only write then restart for reads
// R8: read sends MSB, then LSB after ack
// R9: tolerate ack, nack, start, stop anywhere
// R10: pointer kept across reads until rewritten
// R11: no clock stretching, no PEC
// R12: HS code not acked, filters switched
// R13: restarts keep high-speed operation
// R14: stop leaves high-speed mode
// R15: alert pending: ack ARA, send address
// R16: lost arbitration: no ack, alert held
// R17: signed results in two's complement
// R18: temperature and voltage register full ranges
// R19: energy accumulator wraps past 40 bits
// R20: clear bit zeroes energy any time
// R21: charge overflow flags, cleared by clear
// R22: conversion time and averaging selectable
// R23: address from two four-level select pins
// R24: select pins sampled every transfer
// R25: fast and high-speed rates, MSB first
// R26: ignore non-matching addresses entirely
`include "itr_defines.vh"
`default_nettype none

module itr_port (
   input wire clk,
   input wire rstn,
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output reg sda_oe_ff,
   input wire [1:0] address_select_low_pin,
   input wire [1:0] address_select_high_pin,
   output reg hs_mode_ff,
   input wire alert_pending,
   output wire alert_oe,
   input wire sample_valid,
   input wire [15:0] bus_voltage,
   input wire [11:0] die_temperature,
   input wire [15:0] current,
   input wire [23:0] power,
   input wire [15:0] charge_increment,
   output reg [2:0] conv_time_sel_ff,
   output reg [2:0] avg_count_sel_ff
);

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ADDR_ACK = 3'd2;
   localparam ST_WR_BYTE = 3'd3;
   localparam ST_WR_ACK = 3'd4;
   localparam ST_RD_BYTE = 3'd5;
   localparam ST_RD_ACK = 3'd6;
   localparam integer FS_LIM_I = `ITR_FS_FILT_CYC;
   localparam integer HS_LIM_I = `ITR_HS_FILT_CYC;
   localparam [1:0] FS_LIM = FS_LIM_I[1:0];
   localparam [1:0] HS_LIM = HS_LIM_I[1:0];

   // open drain: the pin is only ever pulled low
   assign sda_o = 1'b0;

   reg [5:0] sync1_ff;
   reg [5:0] sync2_ff;
   wire [1:0] filt;
   reg scl_prev_ff;
   reg sda_prev_ff;
   reg [2:0] state_ff;
   reg [3:0] bitcnt_ff;
   reg [7:0] rx_sh_ff;
   reg [39:0] tx_sh_ff;
   reg [1:0] byte_idx_ff;
   reg [7:0] wr_msb_ff;
   reg [3:0] ptr_ff;
   reg [6:0] own_addr_ff;
   reg rw_ff;
   reg ara_ff;
   reg ara_won_ff;
   reg acc_clear_ff;
   reg [39:0] energy_ff;
   reg [39:0] charge_ff;
   reg charge_ovf_ff;
   reg mem_wr_ff;
   reg [15:0] mem_wdata_ff;
   wire [15:0] mem_rdata;
   reg [39:0] rd_value;

   // every pin passes two flops before any logic reads it
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_ff <= 6'h3f;
         sync2_ff <= 6'h3f;
      end
      else
      begin
         sync1_ff <= {address_select_high_pin, address_select_low_pin, sda_i, scl_i};
         sync2_ff <= sync1_ff;
      end
   end

   // spike filters, shorter in high-speed mode
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_filt
         reg [1:0] cnt_ff;
         reg out_ff;
         wire [1:0] lim = hs_mode_ff ? HS_LIM : FS_LIM;
         always @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               cnt_ff <= 2'h0;
               out_ff <= 1'b1;
            end
            else if (sync2_ff[gi] == out_ff)
               cnt_ff <= 2'h0;
            // R12: filter length follows mode
            else if (cnt_ff >= lim - 2'h1)
            begin
               out_ff <= sync2_ff[gi];
               cnt_ff <= 2'h0;
            end
            else
               cnt_ff <= cnt_ff + 2'h1;
         end
         assign filt[gi] = out_ff;
      end
   endgenerate

   wire scl_f = filt[0];
   wire sda_f = filt[1];
   wire scl_rise = scl_f & ~scl_prev_ff;
   wire scl_fall = ~scl_f & scl_prev_ff;
   wire start_det = scl_f & scl_prev_ff & sda_prev_ff & ~sda_f;
   wire stop_det = scl_f & scl_prev_ff & ~sda_prev_ff & sda_f;
   wire [7:0] rx_byte = rx_sh_ff;

   // R23: pin levels 0 gnd, 1 supply, 2 sda, 3 scl
   wire [6:0] pin_addr = `ITR_ADDR_BASE | {3'h0, sync2_ff[5:4], sync2_ff[3:2]};

   // R6: read value chosen by stored pointer, left aligned
   always @*
   begin
      rd_value = 40'h00_0000_0000;
      case (ptr_ff)
         // R17: signed fields passed as two's complement
         `ITR_REG_BUS_VOLTAGE: rd_value = {bus_voltage, 24'h00_0000};
         // R18: 12 bits at 125 mC span -256 to +255.875
         `ITR_REG_DIE_TEMP: rd_value = {die_temperature, 4'h0, 24'h00_0000};
         `ITR_REG_CURRENT: rd_value = {current, 24'h00_0000};
         `ITR_REG_POWER: rd_value = {power, 16'h0000};
         `ITR_REG_ENERGY: rd_value = energy_ff;
         `ITR_REG_CHARGE: rd_value = charge_ff;
         `ITR_REG_DIAG: rd_value = {15'h0000, charge_ovf_ff, 24'h00_0000};
         default:
         begin
            if (ptr_ff <= `ITR_REG_LAST_RW)
               rd_value = {mem_rdata, 24'h00_0000};
            else
               rd_value = 40'h00_0000_0000;
         end
      endcase
   end

   // R11: scl is never driven, so no stretching
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         state_ff <= ST_IDLE;
         bitcnt_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         tx_sh_ff <= 40'h00_0000_0000;
         byte_idx_ff <= 2'h0;
         wr_msb_ff <= 8'h00;
         ptr_ff <= `ITR_PTR_RESET;
         own_addr_ff <= `ITR_ADDR_BASE;
         rw_ff <= 1'b0;
         ara_ff <= 1'b0;
         ara_won_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         hs_mode_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         mem_wdata_ff <= 16'h0000;
         acc_clear_ff <= 1'b0;
         conv_time_sel_ff <= `ITR_ADC_SEL_RESET;
         avg_count_sel_ff <= `ITR_ADC_SEL_RESET;
      end
      else
      begin
         scl_prev_ff <= scl_f;
         sda_prev_ff <= sda_f;
         mem_wr_ff <= 1'b0;
         acc_clear_ff <= 1'b0;
         if (!alert_pending)
            ara_won_ff <= 1'b0;
         if (stop_det)
         begin
            // R5: stop ends any transfer
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
            // R14: stop returns filters to fast mode
            hs_mode_ff <= 1'b0;
         end
         else if (start_det)
         begin
            // R13: restart keeps hs mode as is
            state_ff <= ST_ADDR;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            ara_ff <= 1'b0;
            // R24: address pins taken at each start
            own_addr_ff <= pin_addr;
         end
         else
         begin
            case (state_ff)
               ST_IDLE:
               begin
                  sda_oe_ff <= 1'b0;
               end
               ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     rx_sh_ff <= {rx_sh_ff[6:0], sda_f};
                     bitcnt_ff <= bitcnt_ff + 4'h1;
                  end
                  else if (scl_fall && bitcnt_ff == 4'h8)
                  begin
                     bitcnt_ff <= 4'h0;
                     rw_ff <= rx_byte[0];
                     // R12: hs code recognised, never acked
                     if (rx_byte[7:3] == `ITR_HS_CODE)
                     begin
                        hs_mode_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                     end
                     // R3: ack own address
                     else if (rx_byte[7:1] == own_addr_ff)
                     begin
                        sda_oe_ff <= 1'b1;
                        state_ff <= ST_ADDR_ACK;
                     end
                     // R15: alert response only while pending
                     else if (rx_byte[7:1] == `ITR_ARA_ADDR && rx_byte[0] && alert_pending && !ara_won_ff)
                     begin
                        sda_oe_ff <= 1'b1;
                        ara_ff <= 1'b1;
                        state_ff <= ST_ADDR_ACK;
                     end
                     // R26: others left alone
                     else
                        state_ff <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     byte_idx_ff <= 2'h0;
                     if (rw_ff)
                     begin
                        // R8: first byte out is the msb
                        if (ara_ff)
                           tx_sh_ff <= {own_addr_ff, 1'b0, 32'h0000_0000};
                        else
                           tx_sh_ff <= rd_value;
                        sda_oe_ff <= ara_ff ? ~own_addr_ff[6] : ~rd_value[39];
                        state_ff <= ST_RD_BYTE;
                     end
                     else
                     begin
                        sda_oe_ff <= 1'b0;
                        state_ff <= ST_WR_BYTE;
                     end
                  end
               end
               ST_WR_BYTE:
               begin
                  if (scl_rise)
                  begin
                     rx_sh_ff <= {rx_sh_ff[6:0], sda_f};
                     bitcnt_ff <= bitcnt_ff + 4'h1;
                  end
                  else if (scl_fall && bitcnt_ff == 4'h8)
                  begin
                     bitcnt_ff <= 4'h0;
                     // R4: each data byte acknowledged
                     sda_oe_ff <= 1'b1;
                     state_ff <= ST_WR_ACK;
                     // R1: first byte is the pointer
                     if (byte_idx_ff == 2'h0)
                        // R10: reads never move the pointer
                        ptr_ff <= rx_byte[3:0];
                     else if (byte_idx_ff == 2'h1)
                        wr_msb_ff <= rx_byte;
                     // R4: second data byte completes the word
                     else if (byte_idx_ff == 2'h2 && ptr_ff <= `ITR_REG_LAST_RW)
                     begin
                        mem_wr_ff <= 1'b1;
                        mem_wdata_ff <= {wr_msb_ff, rx_byte};
                        // R20: clear bit pulses the accumulators
                        if (ptr_ff == `ITR_REG_CONFIG)
                           acc_clear_ff <= wr_msb_ff[`ITR_CFG_ACC_CLEAR_BIT - 8];
                        // R22: converter timing selects
                        if (ptr_ff == `ITR_REG_ADC_CONFIG)
                        begin
                           conv_time_sel_ff <= rx_byte[`ITR_ADC_CONV_LSB +: 3];
                           avg_count_sel_ff <= rx_byte[`ITR_ADC_AVG_LSB +: 3];
                        end
                     end
                  end
               end
               ST_WR_ACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_ff <= 1'b0;
                     // extra bytes past the word are acked and dropped
                     if (byte_idx_ff != 2'h3)
                        byte_idx_ff <= byte_idx_ff + 2'h1;
                     state_ff <= ST_WR_BYTE;
                  end
               end
               ST_RD_BYTE:
               begin
                  if (scl_rise)
                  begin
                     bitcnt_ff <= bitcnt_ff + 4'h1;
                     // R16: released one seen low means lost
                     if (ara_ff && !sda_oe_ff && !sda_f)
                        state_ff <= ST_IDLE;
                  end
                  else if (scl_fall)
                  begin
                     // R25: msb leaves first
                     tx_sh_ff <= {tx_sh_ff[38:0], 1'b0};
                     if (bitcnt_ff == 4'h8)
                     begin
                        bitcnt_ff <= 4'h0;
                        sda_oe_ff <= 1'b0;
                        state_ff <= ST_RD_ACK;
                        // R16: alert drops only after a won reply
                        if (ara_ff)
                           ara_won_ff <= 1'b1;
                     end
                     else
                        sda_oe_ff <= ~tx_sh_ff[38];
                  end
               end
               ST_RD_ACK:
               begin
                  // R9: nack ends the read quietly
                  if (scl_rise && sda_f)
                     state_ff <= ST_IDLE;
                  else if (scl_fall)
                  begin
                     // R8: next byte after controller ack
                     sda_oe_ff <= ~tx_sh_ff[39];
                     state_ff <= ST_RD_BYTE;
                  end
               end
               default:
               begin
                  state_ff <= ST_IDLE;
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // R16: alert held until this device wins
   assign alert_oe = alert_pending & ~ara_won_ff;

   // R19: energy wraps; R20: clear has priority
   wire [40:0] energy_sum = {1'b0, energy_ff} + {17'h0_0000, power};
   wire [40:0] charge_sum = {1'b0, charge_ff} + {25'h000_0000, charge_increment};

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         energy_ff <= `ITR_ACC_RESET;
         charge_ff <= `ITR_ACC_RESET;
         charge_ovf_ff <= 1'b0;
      end
      else
      begin
         // R20: accumulators cleared whatever their value
         if (acc_clear_ff)
         begin
            energy_ff <= `ITR_ACC_RESET;
            charge_ff <= `ITR_ACC_RESET;
         end
         else if (sample_valid)
         begin
            energy_ff <= energy_sum[39:0];
            charge_ff <= charge_sum[39:0];
         end
         // R21: overflow sets flag, set beats clear
         if (sample_valid && charge_sum[40])
            charge_ovf_ff <= 1'b1;
         else if (acc_clear_ff)
            charge_ovf_ff <= 1'b0;
      end
   end

   itr_word_mem u_mem (
      .clk(clk),
      .wr_en(mem_wr_ff),
      .wr_addr(ptr_ff),
      .wr_data(mem_wdata_ff),
      .rd_addr(ptr_ff),
      .rd_data_ff(mem_rdata)
   );

endmodule // itr_port

`default_nettype wire

/* File: itr_defines.vh */
`ifndef ITR_DEFINES_VH
`define ITR_DEFINES_VH

// clock and input spike filters
`define ITR_CLK_PERIOD_NS 40
`define ITR_FS_SPIKE_NS 50
`define ITR_HS_SPIKE_NS 10
`define ITR_FS_FILT_CYC ((`ITR_FS_SPIKE_NS + `ITR_CLK_PERIOD_NS - 1) / `ITR_CLK_PERIOD_NS)
`define ITR_HS_FILT_CYC ((`ITR_HS_SPIKE_NS + `ITR_CLK_PERIOD_NS - 1) / `ITR_CLK_PERIOD_NS)

// bus addresses
`define ITR_ADDR_BASE 7'h40
`define ITR_ARA_ADDR 7'h0c
`define ITR_HS_CODE 5'h01

// register pointer values
`define ITR_REG_CONFIG 4'h0
`define ITR_REG_ADC_CONFIG 4'h1
`define ITR_REG_LAST_RW 4'h4
`define ITR_REG_BUS_VOLTAGE 4'h5
`define ITR_REG_DIE_TEMP 4'h6
`define ITR_REG_CURRENT 4'h7
`define ITR_REG_POWER 4'h8
`define ITR_REG_ENERGY 4'h9
`define ITR_REG_CHARGE 4'ha
`define ITR_REG_DIAG 4'hb

// field positions
`define ITR_CFG_ACC_CLEAR_BIT 14
`define ITR_ADC_CONV_LSB 0
`define ITR_ADC_AVG_LSB 3
`define ITR_DIAG_CHARGE_OVF_BIT 0

// reset values
`define ITR_PTR_RESET 4'h0
`define ITR_ADC_SEL_RESET 3'h0
`define ITR_ACC_RESET 40'h00_0000_0000

`endif

/* File: itr_word_mem.v */
`default_nettype none

// small store for the software writable 16-bit words, registered read port
module itr_word_mem (
   input wire clk,
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [15:0] wr_data,
   input wire [3:0] rd_addr,
   output reg [15:0] rd_data_ff
);

   reg [15:0] mem_ff [0:15];
   integer k;

   initial
   begin
      for (k = 0; k < 16; k = k + 1)
         mem_ff[k] = 16'h0000;
      rd_data_ff = 16'h0000;
   end

   always @(posedge clk)
   begin
      if (wr_en)
         mem_ff[wr_addr] <= wr_data;
      rd_data_ff <= mem_ff[rd_addr];
   end

endmodule // itr_word_mem

`default_nettype wire

/* File: itr_port_chk.sv */
`default_nettype none
module itr_port_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_ff,
   input wire logic hs_mode_ff,
   input wire logic alert_pending,
   input wire logic alert_oe,
   input wire logic [2:0] conv_time_sel_ff,
   input wire logic [2:0] avg_count_sel_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // nine bit times at the slowest rate plus slack
   localparam int hold_max = 600;
   int hold_ff;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   always @(posedge clk or negedge rstn)
      if (!rstn)
         hold_ff <= 0;
      else
         hold_ff <= sda_oe_ff ? hold_ff + 1 : 0;
   property p_oe_scl_low;
      $changed(sda_oe_ff) |-> !scl_i;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda drive moved with scl high");
   property p_open_drain;
      sda_oe_ff && scl_i |=> !sda_o && (sda_oe_ff || !scl_i);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda released or driven high with scl high");
   property p_hold;
      sda_oe_ff |-> hold_ff < hold_max;
   endproperty
   a_hold: assert property (p_hold) else $error("sda held too long");
   property p_hs_no_ack;
      $rose(hs_mode_ff) |-> !sda_oe_ff [*8];
   endproperty
   a_hs_no_ack: assert property (p_hs_no_ack) else $error("hs code acked");
   property p_hs_keep;
      hs_mode_ff && scl_i && $fell(sda_i) |=> hs_mode_ff [*8];
   endproperty
   a_hs_keep: assert property (p_hs_keep) else $error("hs lost at restart");
   property p_hs_stop;
      hs_mode_ff && scl_i && $rose(sda_i) |-> ##[1:8] !hs_mode_ff;
   endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("hs kept after stop");
   property p_alert;
      $fell(alert_oe) && alert_pending |-> $fell(sda_oe_ff);
   endproperty
   a_alert: assert property (p_alert) else $error("alert dropped without a won reply");
   property p_cfg_ack;
      $changed({conv_time_sel_ff, avg_count_sel_ff}) |-> ##[0:2] sda_oe_ff;
   endproperty
   a_cfg_ack: assert property (p_cfg_ack) else $error("config moved without ack");
endmodule // itr_port_chk

bind itr_port itr_port_chk u_itr_port_chk (.clk(clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_ff(sda_oe_ff), .hs_mode_ff(hs_mode_ff), .alert_pending(alert_pending), .alert_oe(alert_oe),
   .conv_time_sel_ff(conv_time_sel_ff), .avg_count_sel_ff(avg_count_sel_ff));
`default_nettype wire

/* File: itr_ctrl_model.sv */
`default_nettype none
module itr_ctrl_model (
   input wire logic clk,
   input wire logic sda,
   output var logic scl_lo,
   output var logic sda_lo
);
   timeunit 1ns;
   timeprecision 1ns;
   // quarter bit, 16 gives about 390 kHz
   int q = 16;
   initial
   begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
   end
   task automatic w;
      repeat (q) @(negedge clk);
   endtask
   task automatic start_c;
      sda_lo = 1'b0;
      w();
      scl_lo = 1'b0;
      w();
      sda_lo = 1'b1;
      w();
      scl_lo = 1'b1;
      w();
   endtask
   task automatic stop_c;
      sda_lo = 1'b1;
      w();
      scl_lo = 1'b0;
      w();
      sda_lo = 1'b0;
      w();
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_lo = !b;
      w();
      scl_lo = 1'b0;
      w();
      r = sda;
      w();
      scl_lo = 1'b1;
      w();
   endtask
   // ack or nack sent by caller
   task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(k, a);
   endtask
endmodule // itr_ctrl_model
`default_nettype wire

/* File: itr_testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] a_lo = 2'h2;
   logic [1:0] a_hi = 2'h1;
   logic alert_pending = 1'b0;
   logic sample_valid = 1'b0;
   logic [15:0] bus_voltage = 16'h7fff;
   logic [11:0] die_temperature = 12'h800;
   logic [15:0] current = 16'h8000;
   logic [23:0] power = 24'hfedcba;
   logic [15:0] charge_increment = 16'hf00d;
   wire logic scl_lo, sda_lo, sda_o, sda_oe, hs_mode, alert_oe;
   wire logic [2:0] conv_sel, avg_sel;
   wire logic sda = !(sda_lo || (sda_oe && !sda_o));
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   itr_port u_itr_port (.clk(clk), .rstn(rstn), .scl_i(!scl_lo), .sda_i(sda), .sda_o(sda_o), .sda_oe_ff(sda_oe),
      .address_select_low_pin(a_lo), .address_select_high_pin(a_hi), .hs_mode_ff(hs_mode),
      .alert_pending(alert_pending), .alert_oe(alert_oe), .sample_valid(sample_valid), .bus_voltage(bus_voltage),
      .die_temperature(die_temperature), .current(current), .power(power), .charge_increment(charge_increment),
      .conv_time_sel_ff(conv_sel), .avg_count_sel_ff(avg_sel));
   itr_ctrl_model ctl (.clk(clk), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));
   initial
      forever #20 clk = !clk;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [6:0] dev();
      return {3'h4, a_hi, a_lo};
   endfunction
   task automatic wreg(input logic [6:0] ad, input logic [7:0] ptr, input logic [15:0] v, input int n,
      input logic fin);
      logic [7:0] r;
      logic a;
      ctl.start_c();
      ctl.xfer({ad, 1'b0}, 1'b1, r, a);
      chk(40'(a), 40'h0);
      ctl.xfer(ptr, 1'b1, r, a);
      chk(40'(a), 40'h0);
      for (int i = 0; i < n; i++)
      begin
         ctl.xfer(i ? v[7:0] : v[15:8], 1'b1, r, a);
         chk(40'(a), 40'h0);
      end
      if (fin)
         ctl.stop_c();
   endtask
   task automatic rreg(input logic [6:0] ad, input int n, input logic [39:0] e);
      logic [39:0] v;
      logic [7:0] r;
      logic a;
      v = 40'h0;
      ctl.start_c();
      ctl.xfer({ad, 1'b1}, 1'b1, r, a);
      chk(40'(a), 40'h0);
      for (int i = 0; i < n; i++)
      begin
         ctl.xfer(8'hff, i == n - 1, r, a);
         v = {v[31:0], r};
      end
      ctl.stop_c();
      chk(v, e);
   endtask
   task automatic nack(input logic [6:0] ad);
      logic [7:0] r;
      logic a;
      ctl.start_c();
      ctl.xfer({ad, 1'b1}, 1'b1, r, a);
      ctl.stop_c();
      chk(40'(a), 40'h1);
   endtask
   task automatic t_cfg;
      wreg(dev(), 8'h01, 16'h2b1d, 2, 1'b1);
      chk(40'(conv_sel), 40'h5);
      chk(40'(avg_sel), 40'h3);
      rreg(dev(), 2, 40'h2b1d);
      rreg(dev(), 1, 40'h2b);
      $display("test config done");
   endtask
   task automatic t_res;
      logic [39:0] ex [4];
      int nb [4];
      ex = '{40'h7fff, 40'h8000, 40'h8000, 40'hfedcba};
      nb = '{2, 2, 2, 3};
      for (int i = 0; i < 4; i++)
      begin
         wreg(dev(), 8'(5 + i), 16'h0, 0, 1'b0);
         rreg(dev(), nb[i], ex[i]);
      end
      $display("test results done");
   endtask
   task automatic t_acc;
      power = 24'h123456;
      repeat (3)
      begin
         @(negedge clk) sample_valid = 1'b1;
         @(negedge clk) sample_valid = 1'b0;
      end
      wreg(dev(), 8'h09, 16'h0, 0, 1'b0);
      rreg(dev(), 5, 40'h369d02);
      wreg(dev(), 8'h0a, 16'h0, 0, 1'b0);
      rreg(dev(), 5, 40'h2d027);
      wreg(dev(), 8'h00, 16'h4000, 2, 1'b1);
      wreg(dev(), 8'h09, 16'h0, 0, 1'b0);
      rreg(dev(), 5, 40'h0);
      wreg(dev(), 8'h0b, 16'h0, 0, 1'b0);
      rreg(dev(), 2, 40'h0);
      $display("test accumulators done");
   endtask
   task automatic t_addr;
      nack(dev() ^ 7'h01);
      a_hi = 2'h3;
      a_lo = 2'h0;
      nack(7'h46);
      wreg(dev(), 8'h01, 16'h0, 0, 1'b0);
      rreg(dev(), 2, 40'h2b1d);
      a_hi = 2'h1;
      a_lo = 2'h2;
      $display("test address done");
   endtask
   task automatic t_hs;
      logic [7:0] r;
      logic a;
      ctl.start_c();
      ctl.xfer(8'h0d, 1'b1, r, a);
      chk(40'(a), 40'h1);
      chk(40'(hs_mode), 40'h1);
      ctl.q = 4;
      wreg(dev(), 8'h07, 16'h0, 0, 1'b0);
      chk(40'(hs_mode), 40'h1);
      rreg(dev(), 2, 40'h8000);
      ctl.q = 16;
      repeat (4) @(negedge clk);
      chk(40'(hs_mode), 40'h0);
      $display("test high speed done");
   endtask
   task automatic t_ara;
      logic [7:0] r;
      logic a;
      nack(7'h0c);
      alert_pending = 1'b1;
      @(negedge clk);
      chk(40'(alert_oe), 40'h1);
      // rival pulls a bit this device leaves high, so it must let go
      ctl.start_c();
      ctl.xfer({7'h0c, 1'b1}, 1'b1, r, a);
      chk(40'(a), 40'h0);
      ctl.xfer(8'h87, 1'b1, r, a);
      ctl.stop_c();
      chk(40'(r), 40'h87);
      chk(40'(alert_oe), 40'h1);
      rreg(7'h0c, 1, {32'h0, dev(), 1'b0});
      chk(40'(alert_oe), 40'h0);
      alert_pending = 1'b0;
      $display("test alert done");
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      t_cfg();
      t_res();
      t_acc();
      t_addr();
      t_hs();
      t_ara();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
